// [temp_alert_regs.svh]
// Purpose: constants of the temperature alert and register read block
// Assumes: 125 MHz core clock, Avalon-MM byte addresses, 32-bit data
// Notes:   limits and temperature are 16-bit twos complement words
// Function
// - Configuration read returns the 8-bit byte after the address, repeated in every further byte read.
// - Temperature read returns two bytes, most significant byte first.
// - Alert pin has overtemperature and alert modes; overtemperature after reset.
// - Overtemperature mode offers comparator and interrupt; comparator after reset.
// - Comparator: alert asserts when temperature is at or above the limit.
// - Comparator: alert releases only below hysteresis limit, holds in between.
// - Shutdown leaves the comparator alert state unchanged.
// - Interrupt: alert asserts after the configured consecutive faults.
// - Interrupt: completed two-wire read of any register clears the alert; Avalon reads leave it set.
// - After clearing, alert waits for a new fault at or above the limit.
// - Alert mode is a selectable alternative to overtemperature mode.
// - Fault queue 00/01/10/11 needs one, two, four, six faults; comparator mode ignores it and asserts on one.
// - Polarity clear gives active low alert, set gives active high.
// - Mode bit clear selects comparator, set selects interrupt.
`ifndef TEMP_ALERT_REGS_SVH
`define TEMP_ALERT_REGS_SVH

`define OFS_CONFIG     5'h00
`define OFS_OT_LIMIT   5'h04
`define OFS_HYST_LIMIT 5'h08
`define OFS_TEMP       5'h0c
`define OFS_STATUS     5'h10
`define OFS_MASK       5'h14
`define OFS_ALERT      5'h18

`define CFG_RST        6'h00
`define OT_RST         16'h5000
`define HYST_RST       16'h4b00
`define TEMP_RST       16'h0000

`define PTR_TEMP       2'h0
`define PTR_CONFIG     2'h1
`define PTR_HYST       2'h2
`define PTR_OT         2'h3

`define DEV_ADDR_HI    4'h9
`define BYTE_BITS      4'h8

`define FAULTS_Q0      3'h1
`define FAULTS_Q1      3'h2
`define FAULTS_Q2      3'h4
`define FAULTS_Q3      3'h6

`define ST_ALERT       0
`define ST_READ        1

`endif

// [temp_alert_pkg.sv]
// Purpose: shared types of the temperature alert and register read block
// Assumes: constants live in temp_alert_regs.svh
// Notes:   cfg_t bit order matches the configuration byte
package temp_alert_pkg;

    // Configuration byte, bit 0 first from the bottom
    typedef struct packed {
        logic       smb_alert;
        logic [1:0] fault_q;
        logic       pol;
        logic       int_mode;
        logic       shdn;
    } cfg_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } avs_req_t;

    // One conversion result, done is a one-cycle pulse
    typedef struct packed {
        logic        done;
        logic [15:0] temp;
    } conv_t;

    typedef struct packed {
        logic       ptr_wr;
        logic [1:0] ptr;
        logic       rd_start;
        logic       rd_done;
    } i2c_evt_t;

    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
    } i2c_st_t;

endpackage

// [pin_sync.sv]
// Purpose: two-stage synchroniser for pins outside the core clock domain
// Assumes: pins idle high, so reset loads ones
// Notes:   only the second stage is visible outside
module pin_sync #(
    parameter int W = 5
) (
    input  wire logic         core_clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_st_t;

    sync_st_t s_q;
    sync_st_t s_d;

    // First stage feeds the second and nothing else
    always_comb
    begin
        s_d.meta = d_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            s_q <= '1;
        else
            s_q <= s_d;
    end

    assign q_out = s_q.sync;
endmodule

// [i2c_reg_read.sv]
// Purpose: two-wire slave that sets the pointer and returns register bytes
// Assumes: scl and sda already synchronised, scl far slower than the core clock
// Notes:   only the first written byte is used, as the pointer
`include "temp_alert_regs.svh"
module i2c_reg_read (
    input  wire logic                    core_clk_in,
    input  wire logic                    srst_in,
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    input  wire logic [2:0]              addr_lo_in,
    input  wire logic [7:0]              tx_byte_in,
    output temp_alert_pkg::i2c_evt_t     evt_out,
    output logic                         byte_idx_out,
    output logic                         sda_oe_out
);
    import temp_alert_pkg::*;

    typedef struct packed {
        logic       scl_p;
        logic       sda_p;
        i2c_st_t    st;
        logic [7:0] sh;
        logic [3:0] bits;
        logic       rw;
        logic       first;
        logic       rd_any;
        logic       nack;
        logic       idx;
        logic       oe;
        i2c_evt_t   evt;
    } slv_st_t;

    // Lines idle high: edge detectors start high so reset gives no false edge
    localparam slv_st_t SLV_RST = '{scl_p: 1'b1, sda_p: 1'b1, st: I2C_IDLE, evt: '0,
                                    default: '0};

    slv_st_t s_q;
    slv_st_t s_d;
    logic    rise;
    logic    fall;

    assign rise = scl_in & ~s_q.scl_p;
    assign fall = ~scl_in & s_q.scl_p;

    // Bits sampled on scl rise, sda changed only on scl fall
    always_comb
    begin
        s_d = s_q;
        s_d.evt = '0;
        s_d.scl_p = scl_in;
        s_d.sda_p = sda_in;
        if (s_q.scl_p && scl_in && (s_q.sda_p != sda_in))
        begin
            // Start or stop ends any read in progress
            s_d.evt.rd_done = s_q.rd_any;
            s_d.rd_any = 1'b0;
            s_d.oe = 1'b0;
            s_d.bits = '0;
            s_d.idx = 1'b0;
            s_d.st = sda_in ? I2C_IDLE : I2C_ADDR;
        end
        else if (rise)
        begin
            unique case (s_q.st)
                I2C_ADDR, I2C_WR:
                begin
                    s_d.sh = {s_q.sh[6:0], sda_in};
                    s_d.bits = 4'(s_q.bits + 4'h1);
                end
                I2C_RD: s_d.bits = 4'(s_q.bits + 4'h1);
                I2C_RD_ACK:
                begin
                    s_d.nack = sda_in;
                    s_d.rd_any = 1'b1;
                    s_d.idx = ~s_q.idx;
                end
                I2C_IDLE, I2C_ADDR_ACK, I2C_WR_ACK: ;
            endcase
        end
        else if (fall)
        begin
            unique case (s_q.st)
                I2C_ADDR:
                    if (s_q.bits == `BYTE_BITS)
                    begin
                        if (s_q.sh[7:1] == {`DEV_ADDR_HI, addr_lo_in})
                        begin
                            s_d.oe = 1'b1;
                            s_d.rw = s_q.sh[0];
                            s_d.evt.rd_start = s_q.sh[0];
                            s_d.st = I2C_ADDR_ACK;
                        end
                        else
                            s_d.st = I2C_IDLE;
                    end
                I2C_ADDR_ACK:
                begin
                    s_d.bits = '0;
                    s_d.first = 1'b1;
                    s_d.sh = tx_byte_in;
                    s_d.oe = s_q.rw & ~tx_byte_in[7];
                    s_d.st = s_q.rw ? I2C_RD : I2C_WR;
                end
                I2C_WR:
                    if (s_q.bits == `BYTE_BITS)
                    begin
                        s_d.oe = 1'b1;
                        s_d.st = I2C_WR_ACK;
                        s_d.first = 1'b0;
                        s_d.evt.ptr_wr = s_q.first;
                        s_d.evt.ptr = s_q.sh[1:0];
                    end
                I2C_WR_ACK:
                begin
                    s_d.oe = 1'b0;
                    s_d.bits = '0;
                    s_d.st = I2C_WR;
                end
                I2C_RD:
                    if (s_q.bits == `BYTE_BITS)
                    begin
                        s_d.oe = 1'b0;
                        s_d.st = I2C_RD_ACK;
                    end
                    else
                    begin
                        s_d.sh = {s_q.sh[6:0], 1'b0};
                        s_d.oe = ~s_q.sh[6];
                    end
                I2C_RD_ACK:
                begin
                    // No acknowledge: release and wait for stop
                    s_d.bits = '0;
                    s_d.sh = tx_byte_in;
                    s_d.oe = ~s_q.nack & ~tx_byte_in[7];
                    s_d.st = s_q.nack ? I2C_IDLE : I2C_RD;
                end
                I2C_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            s_q <= SLV_RST;
        else
            s_q <= s_d;
    end

    assign evt_out = s_q.evt;
    assign byte_idx_out = s_q.idx;
    assign sda_oe_out = s_q.oe;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    ptr_first_byte_a: assert property (
        s_q.evt.ptr_wr |-> $past(s_q.st == I2C_WR && s_q.first))
        else $error("pointer taken from a byte other than the first");
    read_end_bus_a: assert property (
        s_q.evt.rd_done |-> s_q.scl_p && $past(s_q.rd_any))
        else $error("read completion outside start or stop");
endmodule

// [temp_alert.sv]
// Purpose: alert pin logic and register read path of a temperature sensor
// Assumes: conversion results arrive on the core clock; scl is sampled
// Notes:   registers over Avalon-MM; two-wire link reads them
`include "temp_alert_regs.svh"
module temp_alert (
    input  wire logic                     core_clk_in,
    input  wire logic                     srst_in,
    input  wire temp_alert_pkg::avs_req_t avs_in,
    output logic [31:0]                   avs_readdata_out,
    output logic                          avs_waitrequest_out,
    input  wire temp_alert_pkg::conv_t    conv_in,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    input  wire logic [2:0]               addr_pins_in,
    output logic                          sda_out,
    output logic                          sda_oe_out,
    output logic                          over_temp_alert_output_out,
    output logic                          over_temp_alert_oe_out,
    output logic                          shutdown_out,
    output logic                          irq_out
);
    import temp_alert_pkg::*;

    typedef struct packed {
        cfg_t        cfg;
        logic [15:0] ot;
        logic [15:0] hyst;
        logic [15:0] temp;
        logic [15:0] snap;
        logic [1:0]  ptr;
        logic [2:0]  cnt;
        logic        active;
        logic        level;
        logic        oe;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        irq;
        logic        wreq;
        logic [31:0] rdata;
    } top_st_t;

    localparam top_st_t ST_RST = '{
        cfg:    `CFG_RST,
        ot:     `OT_RST,
        hyst:   `HYST_RST,
        temp:   `TEMP_RST,
        snap:   `TEMP_RST,
        ptr:    `PTR_TEMP,
        cnt:    '0,
        active: 1'b0,
        level:  1'b1,
        oe:     1'b0,
        status: '0,
        mask:   '0,
        irq:    1'b0,
        wreq:   1'b1,
        rdata:  '0
    };

    top_st_t    s_q;
    top_st_t    s_d;
    logic [4:0] pins_s;
    i2c_evt_t   evt;
    logic       byte_idx;
    logic [7:0] tx_byte;
    logic [15:0] tx_word;
    logic       ge;
    logic       below_h;
    logic       conv_ok;
    logic       latched;
    logic [2:0] need;

    // Faults needed before the latched alert fires
    function automatic logic [2:0] faults_needed(input logic [1:0] fq);
        unique case (fq)
            2'h0: faults_needed = `FAULTS_Q0;
            2'h1: faults_needed = `FAULTS_Q1;
            2'h2: faults_needed = `FAULTS_Q2;
            2'h3: faults_needed = `FAULTS_Q3;
        endcase
    endfunction

    // Link pins cross into the core domain here
    pin_sync #(
        .W(5)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .d_in        ({scl_in, sda_in, addr_pins_in}),
        .q_out       (pins_s)
    );

    i2c_reg_read u_link (
        .core_clk_in  (core_clk_in),
        .srst_in      (srst_in),
        .scl_in       (pins_s[4]),
        .sda_in       (pins_s[3]),
        .addr_lo_in   (pins_s[2:0]),
        .tx_byte_in   (tx_byte),
        .evt_out      (evt),
        .byte_idx_out (byte_idx),
        .sda_oe_out   (sda_oe_out)
    );

    // Compare against limits as signed values
    assign ge = $signed(conv_in.temp) >= $signed(s_q.ot);
    assign below_h = $signed(conv_in.temp) < $signed(s_q.hyst);
    assign conv_ok = conv_in.done && !s_q.cfg.shdn;
    assign latched = s_q.cfg.int_mode || s_q.cfg.smb_alert;
    assign need = faults_needed(s_q.cfg.fault_q);

    // Byte for the link: temperature from a snapshot so halves never tear
    always_comb
    begin
        unique case (s_q.ptr)
            `PTR_TEMP:   tx_word = s_q.snap;
            `PTR_CONFIG: tx_word = {2'b00, s_q.cfg, 2'b00, s_q.cfg};
            `PTR_HYST:   tx_word = s_q.hyst;
            `PTR_OT:     tx_word = s_q.ot;
        endcase
        tx_byte = byte_idx ? tx_word[7:0] : tx_word[15:8];
    end

    // Alert, registers and bus answer in one next-state process
    always_comb
    begin
        s_d = s_q;
        if (evt.ptr_wr)
            s_d.ptr = evt.ptr;
        if (evt.rd_start)
            s_d.snap = s_q.temp;
        // Read clear is applied first so a same-cycle conversion wins
        if (evt.rd_done && latched)
        begin
            s_d.active = 1'b0;
            s_d.cnt = '0;
        end
        if (conv_ok)
        begin
            s_d.temp = conv_in.temp;
            if (!ge)
                s_d.cnt = '0;
            else if (s_d.cnt != need)
                s_d.cnt = 3'(s_d.cnt + 3'h1);
            if (latched)
            begin
                if (ge && s_d.cnt == need && (evt.rd_done || s_q.cnt != need))
                    s_d.active = 1'b1;
            end
            else if (ge)
                s_d.active = 1'b1;
            else if (below_h)
                s_d.active = 1'b0;
        end
        // Avalon: one wait cycle, then a single ready cycle
        if (s_q.wreq)
        begin
            if (avs_in.read || avs_in.write)
            begin
                s_d.wreq = 1'b0;
                unique case (avs_in.address)
                    `OFS_CONFIG:     s_d.rdata = 32'(s_q.cfg);
                    `OFS_OT_LIMIT:   s_d.rdata = 32'(s_q.ot);
                    `OFS_HYST_LIMIT: s_d.rdata = 32'(s_q.hyst);
                    `OFS_TEMP:       s_d.rdata = 32'(s_q.temp);
                    `OFS_STATUS:     s_d.rdata = 32'(s_q.status);
                    `OFS_MASK:       s_d.rdata = 32'(s_q.mask);
                    `OFS_ALERT:      s_d.rdata = 32'({s_q.cnt, s_q.level, s_q.active});
                    default:         s_d.rdata = '0;
                endcase
            end
        end
        else
        begin
            s_d.wreq = 1'b1;
            if (avs_in.write)
            begin
                unique case (avs_in.address)
                    `OFS_CONFIG:     s_d.cfg = cfg_t'(avs_in.writedata[5:0]);
                    `OFS_OT_LIMIT:   s_d.ot = avs_in.writedata[15:0];
                    `OFS_HYST_LIMIT: s_d.hyst = avs_in.writedata[15:0];
                    `OFS_STATUS:     s_d.status = s_q.status & ~avs_in.writedata[1:0];
                    `OFS_MASK:       s_d.mask = avs_in.writedata[1:0];
                    default:         ;
                endcase
            end
        end
        // Sticky events: a set in the clearing cycle survives
        if (s_d.active && !s_q.active)
            s_d.status[`ST_ALERT] = 1'b1;
        if (evt.rd_done)
            s_d.status[`ST_READ] = 1'b1;
        s_d.irq = |(s_d.status & s_d.mask);
        // Open drain pin pulls low for a low level
        s_d.level = s_d.cfg.pol ? s_d.active : ~s_d.active;
        s_d.oe = ~s_d.level;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            s_q <= ST_RST;
        else
            s_q <= s_d;
    end

    // Open drain: the pin only ever pulls low
    assign sda_out = 1'b0;
    assign avs_readdata_out = s_q.rdata;
    assign avs_waitrequest_out = s_q.wreq;
    assign over_temp_alert_output_out = s_q.level;
    assign over_temp_alert_oe_out = s_q.oe;
    assign shutdown_out = s_q.cfg.shdn;
    assign irq_out = s_q.irq;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence conv_hot;
        conv_ok && ge;
    endsequence

    sequence conv_cool;
        conv_ok && !ge && below_h;
    endsequence

    comp_assert_a: assert property (
        conv_hot ##0 !latched |=> s_q.active)
        else $error("comparator alert missing at or above limit");
    comp_release_a: assert property (
        conv_cool ##0 !latched |=> !s_q.active)
        else $error("comparator alert held below hysteresis");
    comp_band_a: assert property (
        conv_ok && !ge && !below_h && !latched |=> $stable(s_q.active))
        else $error("comparator alert moved inside hysteresis band");
    shdn_hold_a: assert property (
        s_q.cfg.shdn && !latched |=> $stable(s_q.active))
        else $error("alert changed during shutdown");
    int_clear_a: assert property (
        latched && evt.rd_done && !conv_ok |=> !s_q.active)
        else $error("read did not clear latched alert");
    int_queue_a: assert property (
        $rose(s_q.active) && $past(latched) |-> s_q.cnt == $past(need))
        else $error("latched alert fired before fault count");
    fault_restart_a: assert property (
        conv_ok && !ge |=> s_q.cnt == '0)
        else $error("fault counter kept count after cool conversion");
    change_cause_a: assert property (
        $changed(s_q.active) |-> $past(conv_ok || evt.rd_done))
        else $error("alert changed without conversion or read");
    pin_polarity_a: assert property (
        over_temp_alert_output_out == (s_q.cfg.pol ? s_q.active : !s_q.active))
        else $error("alert pin level disagrees with polarity");
    reset_mode_a: assert property (
        $past(srst_in) |-> !s_q.cfg.int_mode && !s_q.cfg.smb_alert && !s_q.active)
        else $error("alert mode not comparator after reset");
    temp_msb_a: assert property (
        s_q.ptr == `PTR_TEMP && !byte_idx |-> tx_byte == s_q.snap[15:8])
        else $error("temperature high byte not sent first");
    bus_ready_a: assert property (
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
endmodule

// [i2c_master_model.sv]
// Purpose: two-wire master that sets the pointer and reads bytes back
// Assumes: open-drain lines, pull-up resolved by the bench
// Notes:   64 ns link clock, stands high between frames
module i2c_master_model (
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both lines released when idle
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // Data moves only while the clock is low
    task automatic put(input logic b);
        sda_low_out = !b;
        #16 scl_out = 1'b1;
        #32 scl_out = 1'b0;
        #16;
    endtask

    // Sample in the middle of the high phase
    task automatic get(output logic b);
        sda_low_out = 1'b0;
        #16 scl_out = 1'b1;
        #16 b = sda_in;
        #16 scl_out = 1'b0;
        #16;
    endtask

    // Start or repeated start
    task automatic start();
        sda_low_out = 1'b0;
        #16 scl_out = 1'b1;
        #32 sda_low_out = 1'b1;
        #32 scl_out = 1'b0;
        #16;
    endtask

    task automatic wbyte(input logic [7:0] v, output logic nak);
        for (int i = 7; i >= 0; i--)
            put(v[i]);
        get(nak);
    endtask

    // Pointer write, repeated start, then n bytes, NACK on the last
    task automatic read_reg(input logic [2:0] a, input logic [1:0] p, input int n,
                            output logic [15:0] d, output logic nak);
        logic b;
        logic k;
        d = 16'h0000;
        start();
        wbyte({4'h9, a, 1'b0}, nak);
        wbyte({6'h00, p}, k);
        nak = nak | k;
        start();
        wbyte({4'h9, a, 1'b1}, k);
        nak = nak | k;
        for (int j = 0; j < n; j++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                get(b);
                d = {d[14:0], b};
            end
            put(j == n - 1);
        end
        // Stop: data rises while the clock is high
        sda_low_out = 1'b1;
        #16 scl_out = 1'b1;
        #32 sda_low_out = 1'b0;
        #32;
    endtask
endmodule

// [testbench.sv]
// Purpose: self-checking bench of the temperature alert block
// Assumes: Avalon master and two-wire master both driven here
// Notes:   read answers are matched against a queue of notes
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import temp_alert_pkg::*;

    logic        core_clk_in = 1'b0;
    logic        srst_in     = 1'b1;
    avs_req_t    avs         = '0;
    conv_t       conv        = '0;
    logic [2:0]  apins       = 3'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic        sda_o;
    logic        sda_oe;
    logic        pin;
    logic        pin_oe;
    logic        shdn;
    logic        irq;
    logic        scl;
    logic        m_low;
    logic [15:0] d;
    logic [15:0] t;
    logic        nak;
    logic [31:0] c;
    int          n;
    int          err_total    = 0;
    int          total_checks = 0;
    int          seed         = 32'h4d43;
    logic [31:0] exp_q[$];
    // Config, temperature, expected pin level
    logic [23:0] tab[8] = '{24'h0_5000_0, 24'h0_4c00_0, 24'h1_0000_0, 24'h0_4b00_0,
                            24'h0_4aff_1, 24'h4_0000_0, 24'h4_5000_1, 24'h0_0000_1};
    // Open drain with pull-up
    wire         sda = !(m_low | sda_oe);

    always #4 core_clk_in = !core_clk_in;

    temp_alert temp_alert_inst (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .avs_in(avs),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .conv_in(conv),
        .scl_in(scl), .sda_in(sda), .addr_pins_in(apins), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .over_temp_alert_output_out(pin),
        .over_temp_alert_oe_out(pin_oe), .shutdown_out(shdn), .irq_out(irq)
    );

    i2c_master_model i2c_master_model_inst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic miss(input string m);
        err_total++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
            miss($sformatf("got %h expected %h", g, e));
    endtask

    task automatic chk_bit(input logic e, input logic g, input string m);
        total_checks++;
        if (g !== e)
            miss(m);
    endtask

    // Request held until waitrequest is sampled low at a rising edge, bounded wait
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge core_clk_in);
        avs <= '{read: !w, write: w, address: a, writedata: v};
        do
        begin
            @(posedge core_clk_in);
            k++;
        end
        while (wreq !== 1'b0 && k < 20);
        if (wreq !== 1'b0)
        begin
            miss("bus timeout");
            test_done();
        end
        avs.read <= 1'b0;
        avs.write <= 1'b0;
        @(negedge core_clk_in);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // One-cycle conversion pulse, pin looked at once settled
    task automatic cv(input logic [15:0] v);
        @(posedge core_clk_in);
        conv <= '{done: 1'b1, temp: v};
        @(posedge core_clk_in);
        conv.done <= 1'b0;
        @(negedge core_clk_in);
    endtask

    task automatic link(input logic [1:0] p, input int k, input logic [15:0] e);
        i2c_master_model_inst.read_reg(apins, p, k, d, nak);
        repeat (8) @(negedge core_clk_in);
        chk_bit(1'b0, nak, "no ack");
        chk_word({16'h0, e}, {16'h0, d});
    endtask

    // Oldest note against each read answer
    always @(posedge core_clk_in)
        if (avs.read && wreq === 1'b0)
            chk_word(exp_q.pop_front(), rdata);

    // Main sequence
    initial
    begin
        apins <= 3'($random(seed));
        repeat (20) @(posedge core_clk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        rd(5'h00, 32'h0);
        rd(5'h04, 32'h5000);
        rd(5'h08, 32'h4b00);
        rd(5'h0c, 32'h0);
        chk_bit(1'b1, pin, "idle pin");
        chk_bit(1'b0, pin_oe, "idle drive");
        chk_bit(1'b0, sda_o, "sda level");
        bus(1'b1, 5'h1c, 32'hffff);
        rd(5'h1c, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, 5'h00, {28'h0, tab[i][23:20]});
            cv(tab[i][19:4]);
            chk_bit(tab[i][0], pin, "comparator");
            chk_bit(!tab[i][0], pin_oe, "alert drive");
            chk_bit(tab[i][20], shdn, "shutdown pin");
        end
        $display("test comparator done");
        bus(1'b1, 5'h14, 32'h1);
        for (int q = 0; q < 4; q++)
        begin
            n = (q == 0) ? 1 : 2 * q;
            c = {26'h0, q == 3, 2'(q), 1'b0, q != 3, 1'b0};
            bus(1'b1, 5'h00, c);
            bus(1'b1, 5'h10, 32'h3);
            repeat (n - 1) cv(16'h5000);
            cv(16'h1000);
            repeat (n - 1) cv(16'h5000);
            chk_bit(1'b1, pin, "early alert");
            cv(16'h5000);
            chk_bit(1'b0, pin, "interrupt set");
            chk_bit(1'b1, irq, "irq set");
            link(2'h1, 1, {8'h0, c[7:0]});
            chk_bit(1'b1, pin, "read clear");
            cv(16'h1000);
            chk_bit(1'b1, pin, "reassert");
            bus(1'b1, 5'h10, 32'h3);
            chk_bit(1'b0, irq, "irq clear");
        end
        $display("test interrupt done");
        bus(1'b1, 5'h00, 32'h0);
        t = 16'($random(seed));
        cv(t);
        link(2'h0, 2, t);
        link(2'h3, 2, 16'h5000);
        rd(5'h0c, {16'h0, t});
        $display("test link read done");
        test_done();
    end
endmodule
